// *** rtl/cvir_pkg.sv ***
// Shared offsets, field layouts and reset values of the CPU/virtual register bank
package cvir_pkg;

	// ************************************************************
	// Frame selection
	// ************************************************************
	typedef enum logic [1:0] {
		FRAME_CPU,
		FRAME_HYP,
		FRAME_VCPU,
		FRAME_NONE
	} cvir_frame_e;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 32;
	localparam int LIST_N = 4;

	// ************************************************************
	// CPU and virtual CPU interface offsets (same layout)
	// ************************************************************
	localparam logic [12:0] OFF_CONTROL        = 13'h0000;
	localparam logic [12:0] OFF_PRIORITY_MASK  = 13'h0004;
	localparam logic [12:0] OFF_BINARY_POINT   = 13'h0008;
	localparam logic [12:0] OFF_ACKNOWLEDGE    = 13'h000c;
	localparam logic [12:0] OFF_END_OF_INT     = 13'h0010;
	localparam logic [12:0] OFF_RUNNING_PRIO   = 13'h0014;
	localparam logic [12:0] OFF_HIGHEST_PEND   = 13'h0018;
	localparam logic [12:0] OFF_ALIAS_BIN_PT   = 13'h001c;
	localparam logic [12:0] OFF_ALIAS_ACK      = 13'h0020;
	localparam logic [12:0] OFF_ALIAS_EOI      = 13'h0024;
	localparam logic [12:0] OFF_ALIAS_HIGHEST  = 13'h0028;
	localparam logic [12:0] OFF_ACTIVE_PRIO    = 13'h00d0;
	localparam logic [12:0] OFF_NS_ACTIVE_PRIO = 13'h00e0;
	localparam logic [12:0] OFF_IDENT          = 13'h00fc;
	localparam logic [12:0] OFF_DEACTIVATE     = 13'h1000;

	// ************************************************************
	// Hypervisor control frame offsets
	// ************************************************************
	localparam logic [12:0] OFF_HYP_CONTROL    = 13'h0000;
	localparam logic [12:0] OFF_HYP_VIRT_TYPE  = 13'h0004;
	localparam logic [12:0] OFF_HYP_VM_CONTROL = 13'h0008;
	localparam logic [12:0] OFF_HYP_MAINT      = 13'h0010;
	localparam logic [12:0] OFF_HYP_EOI_STAT   = 13'h0020;
	localparam logic [12:0] OFF_HYP_EMPTY_LIST = 13'h0030;
	localparam logic [12:0] OFF_HYP_ACTIVE_PR  = 13'h00f0;
	localparam logic [12:0] OFF_HYP_LIST_BASE  = 13'h0100;
	localparam logic [12:0] OFF_HYP_LIST_STEP  = 13'h0004;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
	localparam logic [31:0] RST_NO_INT_ID    = 32'h0000_03ff;
	localparam logic [31:0] RST_IDLE_PRIO    = 32'h0000_00ff;
	localparam logic [31:0] RST_VIRT_TYPE    = 32'h9000_0003;
	localparam logic [31:0] RST_VM_CONTROL   = 32'h004c_0000;
	localparam logic [31:0] RST_EMPTY_LIST   = 32'h0000_000f;
	localparam logic [2:0]  BPR_S_RESET      = 3'h2;
	localparam logic [2:0]  BPR_S_MIN        = 3'h2;
	localparam logic [2:0]  BPR_NS_RESET     = 3'h3;
	localparam logic [2:0]  BPR_NS_MIN       = 3'h3;
	localparam logic [2:0]  VBPR_RESET       = 3'h2;
	localparam logic [2:0]  VABPR_RESET      = 3'h3;
	localparam logic [2:0]  VBPR_MIN         = 3'h0;
	localparam int          BPR_W            = 3;

	// ************************************************************
	// Identification layout; codes are arbitrary neutral values
	// ************************************************************
	localparam int          ID_PRODUCT_LSB   = 20;
	localparam int          ID_ARCH_LSB      = 16;
	localparam int          ID_REVISION_LSB  = 12;
	localparam int          ID_IMPL_LSB      = 0;
	localparam logic [11:0] ID_PRODUCT       = 12'h0aa; // Arbitrary
	localparam logic [3:0]  ID_ARCH_VERSION  = 4'h2;
	localparam logic [3:0]  ID_REVISION      = 4'h0;    // Arbitrary
	localparam logic [11:0] ID_IMPLEMENTER   = 12'h555; // Arbitrary

endpackage : cvir_pkg

// *** rtl/cvir_binpt.sv ***
// Binary point register with a floor on the stored value
`timescale 1ns/1ps

module cvir_binpt #(
	parameter logic [2:0] RESET_VAL = 3'h2,
	parameter logic [2:0] MIN_VAL   = 3'h0
) (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_b_in,
	// Write port
	input  wire logic       wr_in,
	input  wire logic [2:0] wdata_in,
	// Stored value
	output logic      [2:0] value_out
);

	// ************************************************************
	// Floor function
	// ************************************************************
	// Small writes are raised, never rejected, so software sees a
	// legal value on read back
	function automatic logic [2:0] floor_val(input logic [2:0] v);
		floor_val = (v < MIN_VAL) ? MIN_VAL : v;
	endfunction

	// Storage
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			value_out <= RESET_VAL;
		end else if (wr_in) begin
			value_out <= floor_val(wdata_in);
		end
	end

endmodule // cvir_binpt

// *** rtl/cvir_regs.sv ***
// Physical CPU, hypervisor control and virtual CPU register banks
//
// Contract
// - Secure binary point never below 2, non-secure copy never below 3.
// - Binary point resets to 2 for secure reads, non-secure copy to 3.
// - Aliased binary point resets to 3; the physical one never holds less than 3.
// - Highest-pending reads ignore the group enable bits of control.
// - Physical aliased registers and non-secure active priority answer secure only.
// - Acknowledge and highest-pending registers read 0x3ff after reset.
// - Running priority reads 0xff after reset in both interfaces.
// - Control, priority mask, active priority reset to zero, read-write.
// - End-of-interrupt registers at 0x10 and 0x24 are write-only.
// - Deactivate at 0x1000 in both CPU interfaces, write-only.
// - Virtual binary point resets to 2, virtual aliased copy to 3.
// - Unlisted virtual CPU offsets read zero and ignore writes.
// - Identification: product, architecture, revision, implementer fields.
// - Identification architecture field reads 2.
// - Virtual identification equals physical identification.
// - Type reads 0x90000003, VM control 0x4c0000, empty list 0xf.
// - Hyp control, list entries read-write; status registers read-only.
// - 32-bit bus, every input synchronous to the one clock.
`timescale 1ns/1ps

module cvir_regs (
	// Clock and reset
	input  wire logic         clock_in,
	input  wire logic         rst_b_in,
	// Register access port
	input  wire logic         bus_req_in,
	input  wire logic         bus_write_in,
	input  wire logic [1:0]   bus_frame_in,
	input  wire logic [12:0]  bus_addr_in,
	input  wire logic [31:0]  bus_wdata_in,
	input  wire logic         bus_secure_in,
	output logic              bus_ack_out,
	output logic      [31:0]  bus_rdata_out,
	// Status from the priority engine
	input  wire logic [31:0]  cpu_ack_in,
	input  wire logic [31:0]  cpu_alias_ack_in,
	input  wire logic [31:0]  cpu_running_in,
	input  wire logic [31:0]  cpu_pending_in,
	input  wire logic [31:0]  cpu_alias_pending_in,
	input  wire logic [31:0]  vcpu_ack_in,
	input  wire logic [31:0]  vcpu_alias_ack_in,
	input  wire logic [31:0]  vcpu_running_in,
	input  wire logic [31:0]  vcpu_pending_in,
	input  wire logic [31:0]  vcpu_alias_pending_in,
	// Status from the list logic
	input  wire logic [31:0]  hyp_maint_in,
	input  wire logic [31:0]  hyp_eoi_stat_in,
	input  wire logic [31:0]  hyp_empty_in,
	// Configuration to the engine
	output logic      [31:0]  cpu_if_control_out,
	output logic      [31:0]  cpu_priority_mask_out,
	output logic      [2:0]   cpu_bpr_secure_out,
	output logic      [2:0]   cpu_bpr_nonsecure_out,
	output logic      [31:0]  vcpu_control_out,
	output logic      [31:0]  vcpu_priority_mask_out,
	output logic      [2:0]   vcpu_bpr_out,
	output logic      [2:0]   vcpu_alias_bpr_out,
	output logic      [31:0]  hyp_control_out,
	output logic      [31:0]  hyp_vm_control_out,
	output logic      [127:0] hyp_list_entries_out,
	// Event pulses to the engine
	output logic              cpu_ack_pulse_out,
	output logic              cpu_alias_ack_pulse_out,
	output logic              cpu_eoi_pulse_out,
	output logic              cpu_alias_eoi_pulse_out,
	output logic              cpu_deact_pulse_out,
	output logic              vcpu_ack_pulse_out,
	output logic              vcpu_alias_ack_pulse_out,
	output logic              vcpu_eoi_pulse_out,
	output logic              vcpu_alias_eoi_pulse_out,
	output logic              vcpu_deact_pulse_out,
	output logic      [31:0]  event_data_out
);

	// ************************************************************
	// Address decode helpers
	// ************************************************************
	function automatic logic at(input logic [12:0] a,
		input logic [12:0] off);
		at = (a == off);
	endfunction

	logic        wr;
	logic        rd;
	logic        in_cpu;
	logic        in_hyp;
	logic        in_vcpu;
	logic        sec;
	logic [31:0] ident;

	// Inputs are on the device clock already, so no synchroniser
	assign wr      = bus_req_in & bus_write_in;
	assign rd      = bus_req_in & ~bus_write_in;
	assign in_cpu  = bus_frame_in == cvir_pkg::FRAME_CPU;
	assign in_hyp  = bus_frame_in == cvir_pkg::FRAME_HYP;
	assign in_vcpu = bus_frame_in == cvir_pkg::FRAME_VCPU;
	assign sec     = bus_secure_in;

	// Identification word, shared by both CPU interfaces
	assign ident = (32'(cvir_pkg::ID_PRODUCT) << cvir_pkg::ID_PRODUCT_LSB)
		| (32'(cvir_pkg::ID_ARCH_VERSION) << cvir_pkg::ID_ARCH_LSB)
		| (32'(cvir_pkg::ID_REVISION) << cvir_pkg::ID_REVISION_LSB)
		| (32'(cvir_pkg::ID_IMPLEMENTER) << cvir_pkg::ID_IMPL_LSB);

	// ************************************************************
	// Physical CPU interface storage
	// ************************************************************
	logic [31:0] cpu_apr_q;
	logic [31:0] cpu_nsapr_q;
	logic        bpr_s_wr;
	logic        bpr_ns_wr;

	// Plain read-write words
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cpu_if_control_out    <= cvir_pkg::RST_ZERO;
			cpu_priority_mask_out <= cvir_pkg::RST_ZERO;
			cpu_apr_q             <= cvir_pkg::RST_ZERO;
			cpu_nsapr_q           <= cvir_pkg::RST_ZERO;
		end else if (wr && in_cpu) begin
			if (at(bus_addr_in, cvir_pkg::OFF_CONTROL)) begin
				cpu_if_control_out <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_PRIORITY_MASK)) begin
				cpu_priority_mask_out <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_ACTIVE_PRIO)) begin
				cpu_apr_q <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_NS_ACTIVE_PRIO)
				&& sec) begin
				cpu_nsapr_q <= bus_wdata_in;
			end
		end
	end

	// Secure access picks the secure copy; the alias reaches the other
	assign bpr_s_wr  = wr && in_cpu && sec
		&& at(bus_addr_in, cvir_pkg::OFF_BINARY_POINT);
	assign bpr_ns_wr = wr && in_cpu
		&& ((at(bus_addr_in, cvir_pkg::OFF_BINARY_POINT) && !sec)
		|| (at(bus_addr_in, cvir_pkg::OFF_ALIAS_BIN_PT) && sec));

	// Secure banked copy
	cvir_binpt #(
		.RESET_VAL (cvir_pkg::BPR_S_RESET),
		.MIN_VAL   (cvir_pkg::BPR_S_MIN)
	) u_bpr_s (
		.clock_in  (clock_in),
		.rst_b_in  (rst_b_in),
		.wr_in     (bpr_s_wr),
		.wdata_in  (bus_wdata_in[2:0]),
		.value_out (cpu_bpr_secure_out)
	);

	// Non-secure banked copy, also the aliased register
	cvir_binpt #(
		.RESET_VAL (cvir_pkg::BPR_NS_RESET),
		.MIN_VAL   (cvir_pkg::BPR_NS_MIN)
	) u_bpr_ns (
		.clock_in  (clock_in),
		.rst_b_in  (rst_b_in),
		.wr_in     (bpr_ns_wr),
		.wdata_in  (bus_wdata_in[2:0]),
		.value_out (cpu_bpr_nonsecure_out)
	);

	// ************************************************************
	// Virtual CPU interface storage
	// ************************************************************
	logic [31:0] vcpu_apr_q;
	logic        vbpr_wr;
	logic        vabpr_wr;

	// Plain read-write words; unlisted offsets fall through untouched
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			vcpu_control_out       <= cvir_pkg::RST_ZERO;
			vcpu_priority_mask_out <= cvir_pkg::RST_ZERO;
			vcpu_apr_q             <= cvir_pkg::RST_ZERO;
		end else if (wr && in_vcpu) begin
			if (at(bus_addr_in, cvir_pkg::OFF_CONTROL)) begin
				vcpu_control_out <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_PRIORITY_MASK)) begin
				vcpu_priority_mask_out <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_ACTIVE_PRIO)) begin
				vcpu_apr_q <= bus_wdata_in;
			end
		end
	end

	assign vbpr_wr  = wr && in_vcpu
		&& at(bus_addr_in, cvir_pkg::OFF_BINARY_POINT);
	assign vabpr_wr = wr && in_vcpu
		&& at(bus_addr_in, cvir_pkg::OFF_ALIAS_BIN_PT);

	// Virtual binary point
	cvir_binpt #(
		.RESET_VAL (cvir_pkg::VBPR_RESET),
		.MIN_VAL   (cvir_pkg::VBPR_MIN)
	) u_vbpr (
		.clock_in  (clock_in),
		.rst_b_in  (rst_b_in),
		.wr_in     (vbpr_wr),
		.wdata_in  (bus_wdata_in[2:0]),
		.value_out (vcpu_bpr_out)
	);

	// Virtual aliased binary point
	cvir_binpt #(
		.RESET_VAL (cvir_pkg::VABPR_RESET),
		.MIN_VAL   (cvir_pkg::VBPR_MIN)
	) u_vabpr (
		.clock_in  (clock_in),
		.rst_b_in  (rst_b_in),
		.wr_in     (vabpr_wr),
		.wdata_in  (bus_wdata_in[2:0]),
		.value_out (vcpu_alias_bpr_out)
	);

	// ************************************************************
	// Hypervisor control frame storage
	// ************************************************************
	logic [31:0] hyp_apr_q;

	// Control words
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			hyp_control_out    <= cvir_pkg::RST_ZERO;
			hyp_vm_control_out <= cvir_pkg::RST_VM_CONTROL;
			hyp_apr_q          <= cvir_pkg::RST_ZERO;
		end else if (wr && in_hyp) begin
			if (at(bus_addr_in, cvir_pkg::OFF_HYP_CONTROL)) begin
				hyp_control_out <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_HYP_VM_CONTROL)) begin
				hyp_vm_control_out <= bus_wdata_in;
			end else if (at(bus_addr_in, cvir_pkg::OFF_HYP_ACTIVE_PR)) begin
				hyp_apr_q <= bus_wdata_in;
			end
		end
	end

	// List entries, one word each
	genvar gi;
	generate
		for (gi = 0; gi < cvir_pkg::LIST_N; gi++) begin : g_list
			localparam logic [12:0] OFF = cvir_pkg::OFF_HYP_LIST_BASE
				+ 13'(gi) * cvir_pkg::OFF_HYP_LIST_STEP;
			always_ff @(posedge clock_in) begin
				if (!rst_b_in) begin
					hyp_list_entries_out[gi*32 +: 32] <= cvir_pkg::RST_ZERO;
				end else if (wr && in_hyp && at(bus_addr_in, OFF)) begin
					hyp_list_entries_out[gi*32 +: 32] <= bus_wdata_in;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Status capture
	// ************************************************************
	// Engine status is registered so that reads show the reset values
	// until the engine has run; costs one cycle of staleness
	logic [31:0] cpu_ack_q;
	logic [31:0] cpu_aack_q;
	logic [31:0] cpu_rpr_q;
	logic [31:0] cpu_hpp_q;
	logic [31:0] cpu_ahpp_q;
	logic [31:0] vcpu_ack_q;
	logic [31:0] vcpu_aack_q;
	logic [31:0] vcpu_rpr_q;
	logic [31:0] vcpu_hpp_q;
	logic [31:0] vcpu_ahpp_q;
	logic [31:0] hyp_maint_q;
	logic [31:0] hyp_eoi_q;
	logic [31:0] hyp_empty_q;

	// Sampled every cycle
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cpu_ack_q   <= cvir_pkg::RST_NO_INT_ID;
			cpu_aack_q  <= cvir_pkg::RST_NO_INT_ID;
			cpu_rpr_q   <= cvir_pkg::RST_IDLE_PRIO;
			cpu_hpp_q   <= cvir_pkg::RST_NO_INT_ID;
			cpu_ahpp_q  <= cvir_pkg::RST_NO_INT_ID;
			vcpu_ack_q  <= cvir_pkg::RST_NO_INT_ID;
			vcpu_aack_q <= cvir_pkg::RST_NO_INT_ID;
			vcpu_rpr_q  <= cvir_pkg::RST_IDLE_PRIO;
			vcpu_hpp_q  <= cvir_pkg::RST_NO_INT_ID;
			vcpu_ahpp_q <= cvir_pkg::RST_NO_INT_ID;
			hyp_maint_q <= cvir_pkg::RST_ZERO;
			hyp_eoi_q   <= cvir_pkg::RST_ZERO;
			hyp_empty_q <= cvir_pkg::RST_EMPTY_LIST;
		end else begin
			cpu_ack_q   <= cpu_ack_in;
			cpu_aack_q  <= cpu_alias_ack_in;
			cpu_rpr_q   <= cpu_running_in;
			cpu_hpp_q   <= cpu_pending_in;
			cpu_ahpp_q  <= cpu_alias_pending_in;
			vcpu_ack_q  <= vcpu_ack_in;
			vcpu_aack_q <= vcpu_alias_ack_in;
			vcpu_rpr_q  <= vcpu_running_in;
			vcpu_hpp_q  <= vcpu_pending_in;
			vcpu_ahpp_q <= vcpu_alias_pending_in;
			hyp_maint_q <= hyp_maint_in;
			hyp_eoi_q   <= hyp_eoi_stat_in;
			hyp_empty_q <= hyp_empty_in;
		end
	end

	// ************************************************************
	// Read multiplexer
	// ************************************************************
	logic [31:0] rdata_d;
	logic [12:0] a;

	// Write-only and unlisted offsets fall to zero
	always_comb begin
		a       = bus_addr_in;
		rdata_d = cvir_pkg::RST_ZERO;
		if (in_cpu) begin
			if (at(a, cvir_pkg::OFF_CONTROL)) begin
				rdata_d = cpu_if_control_out;
			end else if (at(a, cvir_pkg::OFF_PRIORITY_MASK)) begin
				rdata_d = cpu_priority_mask_out;
			end else if (at(a, cvir_pkg::OFF_BINARY_POINT)) begin
				rdata_d = sec ? 32'(cpu_bpr_secure_out)
					: 32'(cpu_bpr_nonsecure_out);
			end else if (at(a, cvir_pkg::OFF_ACKNOWLEDGE)) begin
				rdata_d = cpu_ack_q;
			end else if (at(a, cvir_pkg::OFF_RUNNING_PRIO)) begin
				rdata_d = cpu_rpr_q;
			end else if (at(a, cvir_pkg::OFF_HIGHEST_PEND)) begin
				rdata_d = cpu_hpp_q;
			end else if (at(a, cvir_pkg::OFF_ALIAS_BIN_PT) && sec) begin
				rdata_d = 32'(cpu_bpr_nonsecure_out);
			end else if (at(a, cvir_pkg::OFF_ALIAS_ACK) && sec) begin
				rdata_d = cpu_aack_q;
			end else if (at(a, cvir_pkg::OFF_ALIAS_HIGHEST) && sec) begin
				rdata_d = cpu_ahpp_q;
			end else if (at(a, cvir_pkg::OFF_ACTIVE_PRIO)) begin
				rdata_d = cpu_apr_q;
			end else if (at(a, cvir_pkg::OFF_NS_ACTIVE_PRIO) && sec) begin
				rdata_d = cpu_nsapr_q;
			end else if (at(a, cvir_pkg::OFF_IDENT)) begin
				rdata_d = ident;
			end
		end else if (in_vcpu) begin
			if (at(a, cvir_pkg::OFF_CONTROL)) begin
				rdata_d = vcpu_control_out;
			end else if (at(a, cvir_pkg::OFF_PRIORITY_MASK)) begin
				rdata_d = vcpu_priority_mask_out;
			end else if (at(a, cvir_pkg::OFF_BINARY_POINT)) begin
				rdata_d = 32'(vcpu_bpr_out);
			end else if (at(a, cvir_pkg::OFF_ACKNOWLEDGE)) begin
				rdata_d = vcpu_ack_q;
			end else if (at(a, cvir_pkg::OFF_RUNNING_PRIO)) begin
				rdata_d = vcpu_rpr_q;
			end else if (at(a, cvir_pkg::OFF_HIGHEST_PEND)) begin
				rdata_d = vcpu_hpp_q;
			end else if (at(a, cvir_pkg::OFF_ALIAS_BIN_PT)) begin
				rdata_d = 32'(vcpu_alias_bpr_out);
			end else if (at(a, cvir_pkg::OFF_ALIAS_ACK)) begin
				rdata_d = vcpu_aack_q;
			end else if (at(a, cvir_pkg::OFF_ALIAS_HIGHEST)) begin
				rdata_d = vcpu_ahpp_q;
			end else if (at(a, cvir_pkg::OFF_ACTIVE_PRIO)) begin
				rdata_d = vcpu_apr_q;
			end else if (at(a, cvir_pkg::OFF_IDENT)) begin
				rdata_d = ident;
			end
		end else if (in_hyp) begin
			if (at(a, cvir_pkg::OFF_HYP_CONTROL)) begin
				rdata_d = hyp_control_out;
			end else if (at(a, cvir_pkg::OFF_HYP_VIRT_TYPE)) begin
				rdata_d = cvir_pkg::RST_VIRT_TYPE;
			end else if (at(a, cvir_pkg::OFF_HYP_VM_CONTROL)) begin
				rdata_d = hyp_vm_control_out;
			end else if (at(a, cvir_pkg::OFF_HYP_MAINT)) begin
				rdata_d = hyp_maint_q;
			end else if (at(a, cvir_pkg::OFF_HYP_EOI_STAT)) begin
				rdata_d = hyp_eoi_q;
			end else if (at(a, cvir_pkg::OFF_HYP_EMPTY_LIST)) begin
				rdata_d = hyp_empty_q;
			end else if (at(a, cvir_pkg::OFF_HYP_ACTIVE_PR)) begin
				rdata_d = hyp_apr_q;
			end else begin
				for (int i = 0; i < cvir_pkg::LIST_N; i++) begin
					if (at(a, cvir_pkg::OFF_HYP_LIST_BASE
						+ 13'(i) * cvir_pkg::OFF_HYP_LIST_STEP)) begin
						rdata_d = hyp_list_entries_out[i*32 +: 32];
					end
				end
			end
		end
	end

	// Answer one cycle after the request
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			bus_ack_out   <= 1'b0;
			bus_rdata_out <= cvir_pkg::RST_ZERO;
		end else begin
			bus_ack_out   <= bus_req_in;
			bus_rdata_out <= rd ? rdata_d : cvir_pkg::RST_ZERO;
		end
	end

	// ************************************************************
	// Event pulses
	// ************************************************************
	logic cpu_w;
	logic vcpu_w;
	logic cpu_r;
	logic vcpu_r;

	assign cpu_w  = wr && in_cpu;
	assign vcpu_w = wr && in_vcpu;
	assign cpu_r  = rd && in_cpu;
	assign vcpu_r = rd && in_vcpu;

	// Write-only words become pulses; acknowledge reads tell the engine
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			cpu_ack_pulse_out        <= 1'b0;
			cpu_alias_ack_pulse_out  <= 1'b0;
			cpu_eoi_pulse_out        <= 1'b0;
			cpu_alias_eoi_pulse_out  <= 1'b0;
			cpu_deact_pulse_out      <= 1'b0;
			vcpu_ack_pulse_out       <= 1'b0;
			vcpu_alias_ack_pulse_out <= 1'b0;
			vcpu_eoi_pulse_out       <= 1'b0;
			vcpu_alias_eoi_pulse_out <= 1'b0;
			vcpu_deact_pulse_out     <= 1'b0;
			event_data_out           <= cvir_pkg::RST_ZERO;
		end else begin
			cpu_ack_pulse_out <= cpu_r
				&& at(bus_addr_in, cvir_pkg::OFF_ACKNOWLEDGE);
			cpu_alias_ack_pulse_out <= cpu_r && sec
				&& at(bus_addr_in, cvir_pkg::OFF_ALIAS_ACK);
			cpu_eoi_pulse_out <= cpu_w
				&& at(bus_addr_in, cvir_pkg::OFF_END_OF_INT);
			cpu_alias_eoi_pulse_out <= cpu_w && sec
				&& at(bus_addr_in, cvir_pkg::OFF_ALIAS_EOI);
			cpu_deact_pulse_out <= cpu_w
				&& at(bus_addr_in, cvir_pkg::OFF_DEACTIVATE);
			vcpu_ack_pulse_out <= vcpu_r
				&& at(bus_addr_in, cvir_pkg::OFF_ACKNOWLEDGE);
			vcpu_alias_ack_pulse_out <= vcpu_r
				&& at(bus_addr_in, cvir_pkg::OFF_ALIAS_ACK);
			vcpu_eoi_pulse_out <= vcpu_w
				&& at(bus_addr_in, cvir_pkg::OFF_END_OF_INT);
			vcpu_alias_eoi_pulse_out <= vcpu_w
				&& at(bus_addr_in, cvir_pkg::OFF_ALIAS_EOI);
			vcpu_deact_pulse_out <= vcpu_w
				&& at(bus_addr_in, cvir_pkg::OFF_DEACTIVATE);
			if (wr) begin
				event_data_out <= bus_wdata_in; // Held until next write
			end
		end
	end

endmodule // cvir_regs

// *** test/cvir_engine_model.sv ***
// Stand-in for the priority engine that feeds the status inputs
`timescale 1ns/1ps
module cvir_engine_model (
	// Clock
	input  wire logic        clock_in,
	// Status words of an idle engine
	output logic      [31:0] noint_out,
	output logic      [31:0] idle_out,
	output logic      [31:0] empty_out
);
	// Idle words, launched on the clock because the bank does not resync
	always_ff @(posedge clock_in) begin
		noint_out <= 32'h3ff;
		idle_out  <= 32'hff;
		empty_out <= 32'hf;
	end
endmodule // cvir_engine_model

// *** test/cvir_regs_chk.sv ***
// Port-level checks of the register bank
`timescale 1ns/1ps
module cvir_regs_chk (
	// Clock, reset and request
	input wire logic        clock_in,
	input wire logic        rst_b_in,
	input wire logic        bus_req_in,
	input wire logic        bus_write_in,
	input wire logic [1:0]  bus_frame_in,
	input wire logic [12:0] bus_addr_in,
	input wire logic [31:0] bus_wdata_in,
	input wire logic        bus_secure_in,
	// Answer and configuration
	input wire logic        bus_ack_out,
	input wire logic [31:0] bus_rdata_out,
	input wire logic [2:0]  cpu_bpr_secure_out,
	input wire logic [2:0]  cpu_bpr_nonsecure_out,
	input wire logic [31:0] cpu_priority_mask_out,
	input wire logic        cpu_eoi_pulse_out,
	input wire logic        cpu_deact_pulse_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// Request shapes on the physical CPU frame
	wire w0 = bus_req_in && bus_write_in && bus_frame_in == 2'h0;
	wire r0 = bus_req_in && !bus_write_in && bus_frame_in == 2'h0;
	property p_ack; bus_req_in |=> bus_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_wz; bus_req_in && bus_write_in |=> bus_rdata_out == 32'h0;
	endproperty
	a_wz: assert property (p_wz) else $error("write data seen");
	property p_bprs; cpu_bpr_secure_out >= 3'h2; endproperty
	a_bprs: assert property (p_bprs) else $error("bpr floor");
	property p_bprn; cpu_bpr_nonsecure_out >= 3'h3; endproperty
	a_bprn: assert property (p_bprn) else $error("abpr floor");
	property p_pmr; w0 && bus_addr_in == 13'h4 |=>
		cpu_priority_mask_out == $past(bus_wdata_in); endproperty
	a_pmr: assert property (p_pmr) else $error("mask not written");
	property p_eoi; w0 && bus_addr_in == 13'h10 |=> cpu_eoi_pulse_out;
	endproperty
	a_eoi: assert property (p_eoi) else $error("no eoi pulse");
	property p_dir; w0 && bus_addr_in == 13'h1000 |=> cpu_deact_pulse_out;
	endproperty
	a_dir: assert property (p_dir) else $error("no deact pulse");
	property p_nsa; r0 && !bus_secure_in && bus_addr_in inside
		{13'h1c, 13'h20, 13'h28, 13'he0} |=> bus_rdata_out == 32'h0;
	endproperty
	a_nsa: assert property (p_nsa) else $error("secure leak");
endmodule // cvir_regs_chk

// *** test/tb_top.sv ***
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
	logic clock_in = 0, rst_b_in = 0, bus_req_in = 0, bus_write_in = 0;
	logic bus_secure_in = 0, bus_ack_out;
	logic [1:0] bus_frame_in = 0;
	logic [12:0] bus_addr_in = 0;
	logic [2:0] cpu_bpr_secure_out, cpu_bpr_nonsecure_out;
	logic [2:0] vcpu_bpr_out, vcpu_alias_bpr_out;
	logic [31:0] bus_wdata_in = 0, bus_rdata_out, noint, idle, empty;
	logic [31:0] cpu_if_control_out, cpu_priority_mask_out, event_data_out;
	logic [31:0] vcpu_control_out, vcpu_priority_mask_out;
	logic [31:0] hyp_control_out, hyp_vm_control_out;
	logic [127:0] hyp_list_entries_out;
	logic cpu_ack_pulse_out, cpu_alias_ack_pulse_out, cpu_eoi_pulse_out;
	logic cpu_alias_eoi_pulse_out, cpu_deact_pulse_out, vcpu_ack_pulse_out;
	logic vcpu_alias_ack_pulse_out, vcpu_eoi_pulse_out, vcpu_deact_pulse_out;
	logic vcpu_alias_eoi_pulse_out;
	wire [31:0] cpu_ack_in = noint, cpu_alias_ack_in = noint,
		cpu_pending_in = noint, cpu_alias_pending_in = noint,
		vcpu_ack_in = noint, vcpu_alias_ack_in = noint,
		vcpu_pending_in = noint, vcpu_alias_pending_in = noint,
		cpu_running_in = idle, vcpu_running_in = idle, hyp_empty_in = empty,
		hyp_maint_in = 32'h0, hyp_eoi_stat_in = 32'h0;
	int error_cnt = 0, checks = 0;
	localparam logic [31:0] ID = {cvir_pkg::ID_PRODUCT, 4'h2,
		cvir_pkg::ID_REVISION, cvir_pkg::ID_IMPLEMENTER};
	// Rows: frame, secure, offset, value read after reset
	localparam logic [47:0] T [21] = '{{2'h0,1'h1,13'h0,32'h0},
		{2'h0,1'h1,13'h8,32'h2}, {2'h0,1'h0,13'h8,32'h3},
		{2'h0,1'h1,13'hc,32'h3ff}, {2'h0,1'h1,13'h10,32'h0},
		{2'h0,1'h1,13'h14,32'hff}, {2'h0,1'h1,13'h18,32'h3ff},
		{2'h0,1'h1,13'h1c,32'h3}, {2'h0,1'h1,13'h20,32'h3ff},
		{2'h0,1'h1,13'h28,32'h3ff}, {2'h0,1'h1,13'hfc,ID},
		{2'h0,1'h1,13'h1000,32'h0}, {2'h1,1'h1,13'h4,32'h90000003},
		{2'h1,1'h1,13'h8,32'h4c0000}, {2'h1,1'h1,13'h30,32'hf},
		{2'h1,1'h1,13'h10,32'h0}, {2'h2,1'h1,13'h8,32'h2},
		{2'h2,1'h1,13'h1c,32'h3}, {2'h2,1'h1,13'hfc,ID},
		{2'h2,1'h1,13'h30,32'h0}, {2'h3,1'h1,13'h0,32'h0}};
	cvir_engine_model eng (.clock_in, .noint_out(noint),
		.idle_out(idle), .empty_out(empty));
	cvir_regs dut (.*);
	// 25 MHz clock
	initial forever #20 clock_in = ~clock_in;
	task automatic chk(input logic [12:0] a, logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR reg %h exp %h got %h", a, e, g);
		end
	endtask
	// One access, held for one edge; write reads back zero
	task automatic acc(input logic w, logic [1:0] f, logic s,
			logic [12:0] a, logic [31:0] d, e);
		@(negedge clock_in);
		{bus_req_in, bus_write_in, bus_frame_in} = {1'b1, w, f};
		{bus_secure_in, bus_addr_in, bus_wdata_in} = {s, a, d};
		@(negedge clock_in);
		bus_req_in = 0;
		chk(a, 32'h1, {31'h0, bus_ack_out});
		chk(a, e, bus_rdata_out);
	endtask
	task automatic test_done;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Watchdog well beyond the hundred or so cycles needed
	initial begin
		#40000;
		error_cnt++;
		test_done;
	end
	initial begin
		repeat (5) @(negedge clock_in);
		rst_b_in = 1;
		foreach (T[i]) acc(0, T[i][47:46], T[i][45],
			T[i][44:32], 0, T[i][31:0]);
		acc(1, 0, 1, 'h8, 0, 0);
		acc(0, 0, 1, 'h8, 0, 2);
		acc(1, 0, 1, 'h8, 6, 0);
		acc(0, 0, 1, 'h8, 0, 6);
		acc(1, 0, 0, 'h8, 1, 0);
		acc(0, 0, 0, 'h8, 0, 3);
		acc(1, 0, 1, 'h1c, 2, 0);
		acc(0, 0, 1, 'h1c, 0, 3);
		acc(1, 0, 1, 'h1c, 5, 0);
		acc(1, 0, 0, 'h1c, 7, 0);
		acc(0, 0, 1, 'h1c, 0, 5);
		acc(0, 0, 0, 'h20, 0, 0);
		acc(1, 0, 0, 'he0, 5, 0);
		acc(0, 0, 1, 'he0, 0, 0);
		acc(1, 0, 1, 'h4, 'ha5, 0);
		acc(0, 0, 1, 'h4, 0, 'ha5);
		acc(1, 0, 1, 'h10, 'h21, 0);
		chk('h10, 'h21, event_data_out);
		acc(0, 0, 1, 'h24, 0, 0);
		acc(1, 0, 1, 'h1000, 3, 0);
		acc(1, 2, 1, 'h30, 9, 0);
		acc(0, 2, 1, 'h30, 0, 0);
		acc(1, 1, 1, 'h10c, 'h77, 0);
		chk('h10c, 'h77, hyp_list_entries_out[127:96]);
		acc(0, 1, 1, 'h10c, 0, 'h77);
		acc(1, 1, 1, 'h4, 1, 0);
		acc(0, 1, 1, 'h4, 0, 'h90000003);
		// Second reset in mid-run must clear what was written
		rst_b_in = 0;
		repeat (2) @(negedge clock_in);
		rst_b_in = 1;
		acc(0, 0, 1, 'h4, 0, 0);
		acc(0, 1, 1, 'h10c, 0, 0);
		test_done;
	end
endmodule // tb_top
bind cvir_regs cvir_regs_chk chk_i (.*);
